// ---- verilog/pec_pkg.sv ----
// pec_pkg: constants shared by the performance event counter block.
// assumes: included before every other file of the block.
package pec_pkg;

    // widths of the stored state and of one cycle's increment
    localparam int PEC_CNT_W  = 32;
    localparam int PEC_CTRL_W = 9;
    localparam int PEC_INC_W  = 4;

    // coprocessor register number and the select codes from the opcode low bits
    localparam logic [4:0] PEC_COP_REG   = 5'h19;
    localparam logic [1:0] PEC_SEL_CTRL0 = 2'h0;
    localparam logic [1:0] PEC_SEL_CNT0  = 2'h1;
    localparam logic [1:0] PEC_SEL_CTRL1 = 2'h2;
    localparam logic [1:0] PEC_SEL_CNT1  = 2'h3;

    // control register field positions
    localparam int PEC_EVT_MSB    = 8;
    localparam int PEC_EVT_LSB    = 5;
    localparam int PEC_IRQ_EN_BIT = 4;
    localparam int PEC_U_EN_BIT   = 3;
    localparam int PEC_S_EN_BIT   = 2;
    localparam int PEC_K_EN_BIT   = 1;
    localparam int PEC_XLV_EN_BIT = 0;

    // values after reset
    localparam logic [PEC_CTRL_W-1:0] PEC_CTRL_RST  = 9'h000;
    localparam logic [PEC_CNT_W-1:0]  PEC_CNT_RST   = 32'h0000_0000;
    localparam logic [31:0]           PEC_RDATA_RST = 32'h0000_0000;

    // processor privilege encoding on the mode input
    localparam logic [1:0] PEC_KSU_KERNEL = 2'h0;
    localparam logic [1:0] PEC_KSU_SUPER  = 2'h1;
    localparam logic [1:0] PEC_KSU_USER   = 2'h2;

    // event codes with dedicated handling
    localparam logic [3:0] PEC_EV_CYCLES = 4'h0;
    localparam logic [3:0] PEC_EV_INSTR  = 4'h1;
    localparam logic [3:0] PEC_EV_LOAD   = 4'h2;
    localparam logic [3:0] PEC_EV_STORE  = 4'h3;
    localparam logic [3:0] PEC_EV_CST    = 4'h4;
    localparam logic [3:0] PEC_EV_FIVE   = 4'h5;
    localparam int         PEC_EV_HI_LSB = 6;

endpackage : pec_pkg

// ---- verilog/pec_cnt_if.sv ----
// pec_cnt_if: links the core logic to one counter slice.
// assumes: core and slice share one clock.
`timescale 1ns/100ps
interface pec_cnt_if;
    import pec_pkg::*;
    logic                  wr_ctrl;
    logic                  wr_cnt;
    logic [31:0]           wdata;
    logic [PEC_INC_W-1:0]  inc;
    logic [PEC_CTRL_W-1:0] ctrl_q;
    logic [PEC_CNT_W-1:0]  cnt_q;
    logic                  count_ok;

    modport core  (output wr_ctrl, wr_cnt, wdata, inc, input ctrl_q, cnt_q, count_ok);
    modport slice (input wr_ctrl, wr_cnt, wdata, inc, output ctrl_q, cnt_q, count_ok);
endinterface : pec_cnt_if

// ---- verilog/pec_counter_slice.sv ----
// pec_counter_slice: one control register, one counter and its mode qualifier.
// assumes: event selection is done by the core, which supplies the increment.
`timescale 1ns/100ps
module pec_counter_slice
    import pec_pkg::*;
(
    // clock, reset, enable
    input  wire logic       i_core_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_ce,
    // processor mode
    input  wire logic [1:0] i_ksu_mode,
    input  wire logic       i_exception_level_flag,
    input  wire logic       i_error_level_flag,
    // core side
    pec_cnt_if.slice        cnt_if
);

    logic [PEC_CTRL_W-1:0] ctrl_reg;
    logic [PEC_CTRL_W-1:0] ctrl_next;
    logic [PEC_CNT_W-1:0]  cnt_reg;
    logic [PEC_CNT_W-1:0]  cnt_next;
    logic                  mode_ok;

    // mode qualifier; error level blocks everything, even exception mode
    always_comb begin
        mode_ok = 1'b0;
        if (!i_error_level_flag) begin
            if (i_exception_level_flag) begin
                mode_ok = ctrl_reg[PEC_XLV_EN_BIT];
            end else begin
                mode_ok = (ctrl_reg[PEC_U_EN_BIT] && i_ksu_mode == PEC_KSU_USER)
                       || (ctrl_reg[PEC_S_EN_BIT] && i_ksu_mode == PEC_KSU_SUPER)
                       || (ctrl_reg[PEC_K_EN_BIT] && i_ksu_mode == PEC_KSU_KERNEL);
            end
        end
    end

    // next state; a software write beats the increment of the same cycle
    always_comb begin
        ctrl_next = ctrl_reg;
        cnt_next  = cnt_reg;
        if (cnt_if.wr_ctrl) begin
            ctrl_next = cnt_if.wdata[PEC_CTRL_W-1:0];
        end
        if (cnt_if.wr_cnt) begin
            cnt_next = cnt_if.wdata;
        end else if (mode_ok) begin
            // plain modulo add, so counting goes on past bit 31
            cnt_next = cnt_reg + PEC_CNT_W'(cnt_if.inc);
        end
    end

    // state registers, frozen while the enable is low
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_reg <= PEC_CTRL_RST;
            cnt_reg  <= PEC_CNT_RST;
        end else if (i_ce) begin
            ctrl_reg <= ctrl_next;
            cnt_reg  <= cnt_next;
        end
    end

    // outputs to the core
    assign cnt_if.ctrl_q   = ctrl_reg;
    assign cnt_if.cnt_q    = cnt_reg;
    assign cnt_if.count_ok = mode_ok;

endmodule : pec_counter_slice

// ---- verilog/pec_perf_counters.sv ----
// pec_perf_counters: two event counters with control, on coprocessor register 25.
// assumes: all event inputs come from core logic on i_core_clk, one pulse per event;
// the sources already drop re-issues and units-free instructions.
//
// What this block does
// - Two counters, two controls behind one register number, low opcode bits select.
// - Each counter is a 32-bit read/write register incremented by its event.
// - Each counter counts its own selected event, independent of the other.
// - Overflow line asserts when bit 31 is one and interrupt enabled.
// - Counting carries on after overflow, interrupt or not.
// - Event field picks one of sixteen codes; code zero is cycles for both.
// - Codes six to fifteen select counter-specific cache, branch and bus events.
// - User, supervisor, kernel and exception enables qualify counting, any combination.
// - Interrupt enable gates each counter onto the overflow line.
// - Reserved control bits are written zero and always read zero.
// - Code zero adds one every clock cycle.
// - Counter 0 issued: integer done plus float done plus prior-cycle load/store issue.
// - Prefetches count as loads; re-issued loads and stores count once.
// - Instructions using no load/store, integer or float unit are not counted.
// - Counter 1 adds prior-cycle graduations, multiply and divide counted twice.
// - Code two, counter 0: loads, prefetch, sync, cacheop counted at issue, once.
// - Code two, counter 1: same class counted at graduation, up to four per cycle.
// - Code three, counter 0: cycle after first store issue, re-issues ignored.
// - Code three, counter 1: one per graduating store, at most one per cycle.
// - Code four, counter 0: cycle after first store-conditional issue, once only.
// - Code four, counter 1: cycle after store-conditional graduation.
// - Code five, counter 0: one per failed store-conditional.
// - Error level flag set stops all counting in both counters.
// - Control holds event select 8:5, interrupt enable 4, mode enables 3:0.
`timescale 1ns/100ps
module pec_perf_counters
    import pec_pkg::*;
(
    // clock, reset, enable
    input  wire logic        i_core_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_ce,
    // coprocessor moves
    input  wire logic        i_move_to_sys_coproc,
    input  wire logic        i_move_from_sys_coproc,
    input  wire logic [4:0]  i_cop_reg,
    input  wire logic [1:0]  i_cop_sel,
    input  wire logic [31:0] i_cop_wdata,
    output logic      [31:0] o_cop_rdata,
    output logic             o_cop_rvalid,
    // processor mode
    input  wire logic [1:0]  i_ksu_mode,
    input  wire logic        i_exception_level_flag,
    input  wire logic        i_error_level_flag,
    // counter 0 event sources
    input  wire logic [1:0]  i_int_done_cnt,
    input  wire logic [1:0]  i_fp_done_cnt,
    input  wire logic        i_ls_first_issue,
    input  wire logic        i_ld_class_issue,
    input  wire logic        i_st_first_issue,
    input  wire logic        i_store_conditional_first_issue,
    input  wire logic        i_store_conditional_fail,
    input  wire logic [15:6] i_c0_evt_hi,
    // counter 1 event sources
    input  wire logic [3:0]  i_grad_cnt,
    input  wire logic [2:0]  i_ld_class_grad_cnt,
    input  wire logic        i_st_grad,
    input  wire logic        i_store_conditional_grad,
    input  wire logic [2:0]  i_fp_grad_cnt,
    input  wire logic [15:6] i_c1_evt_hi,
    // interrupt
    output logic             o_perf_overflow_irq_line
);

    pec_cnt_if c0_if ();
    pec_cnt_if c1_if ();

    // decoded access
    logic       hit;
    logic       wr_hit;
    logic       rd_hit;
    logic [3:0] ev0;
    logic [3:0] ev1;

    // delayed event state
    logic                 ls_issue_reg;
    logic                 ls_issue_next;
    logic                 st_issue_reg;
    logic                 st_issue_next;
    logic                 cst_issue_reg;
    logic                 cst_issue_next;
    logic                 cst_grad_reg;
    logic                 cst_grad_next;
    logic [PEC_INC_W-1:0] grad_cnt_reg;
    logic [PEC_INC_W-1:0] grad_cnt_next;

    // read port state
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        rvalid_reg;
    logic        rvalid_next;

    // register number decode; the low opcode bits pick one of four
    assign hit    = (i_cop_reg == PEC_COP_REG);
    assign wr_hit = hit && i_move_to_sys_coproc;
    assign rd_hit = hit && i_move_from_sys_coproc;

    // write strobes into the slices
    assign c0_if.wr_ctrl = wr_hit && (i_cop_sel == PEC_SEL_CTRL0);
    assign c0_if.wr_cnt  = wr_hit && (i_cop_sel == PEC_SEL_CNT0);
    assign c1_if.wr_ctrl = wr_hit && (i_cop_sel == PEC_SEL_CTRL1);
    assign c1_if.wr_cnt  = wr_hit && (i_cop_sel == PEC_SEL_CNT1);
    assign c0_if.wdata   = i_cop_wdata;
    assign c1_if.wdata   = i_cop_wdata;

    // each counter decodes its own event field
    assign ev0 = c0_if.ctrl_q[PEC_EVT_MSB:PEC_EVT_LSB];
    assign ev1 = c1_if.ctrl_q[PEC_EVT_MSB:PEC_EVT_LSB];

    // one-cycle delays for events counted on the cycle after they happen
    always_comb begin
        ls_issue_next = i_ls_first_issue;
        st_issue_next = i_st_first_issue;
        cst_issue_next = i_store_conditional_first_issue;
        cst_grad_next  = i_store_conditional_grad;
        grad_cnt_next = i_grad_cnt;
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ls_issue_reg <= 1'b0;
            st_issue_reg <= 1'b0;
            cst_issue_reg <= 1'b0;
            cst_grad_reg  <= 1'b0;
            grad_cnt_reg <= '0;
        end else if (i_ce) begin
            ls_issue_reg <= ls_issue_next;
            st_issue_reg <= st_issue_next;
            cst_issue_reg <= cst_issue_next;
            cst_grad_reg  <= cst_grad_next;
            grad_cnt_reg <= grad_cnt_next;
        end
    end

    // counter 0 increment for the selected event
    always_comb begin
        case (ev0)
            PEC_EV_CYCLES: begin
                c0_if.inc = PEC_INC_W'(1);
            end
            PEC_EV_INSTR: begin
                // sources drop re-issues, prefetch rides the load/store flag
                c0_if.inc = PEC_INC_W'(i_int_done_cnt) + PEC_INC_W'(i_fp_done_cnt)
                          + PEC_INC_W'(ls_issue_reg);
            end
            PEC_EV_LOAD: begin
                c0_if.inc = PEC_INC_W'(i_ld_class_issue);
            end
            PEC_EV_STORE: begin
                c0_if.inc = PEC_INC_W'(st_issue_reg);
            end
            PEC_EV_CST: begin
                c0_if.inc = PEC_INC_W'(cst_issue_reg);
            end
            PEC_EV_FIVE: begin
                c0_if.inc = PEC_INC_W'(i_store_conditional_fail);
            end
            default: begin
                c0_if.inc = PEC_INC_W'(i_c0_evt_hi[ev0]);
            end
        endcase
    end

    // counter 1 increment for the selected event
    always_comb begin
        case (ev1)
            PEC_EV_CYCLES: begin
                c1_if.inc = PEC_INC_W'(1);
            end
            PEC_EV_INSTR: begin
                // the source already weighs multiply and divide as two
                c1_if.inc = grad_cnt_reg;
            end
            PEC_EV_LOAD: begin
                c1_if.inc = PEC_INC_W'(i_ld_class_grad_cnt);
            end
            PEC_EV_STORE: begin
                c1_if.inc = PEC_INC_W'(i_st_grad);
            end
            PEC_EV_CST: begin
                c1_if.inc = PEC_INC_W'(cst_grad_reg);
            end
            PEC_EV_FIVE: begin
                c1_if.inc = PEC_INC_W'(i_fp_grad_cnt);
            end
            default: begin
                c1_if.inc = PEC_INC_W'(i_c1_evt_hi[ev1]);
            end
        endcase
    end

    // read mux; controls are zero-extended so reserved bits read zero
    always_comb begin
        rdata_next  = rdata_reg;
        rvalid_next = rd_hit;
        if (rd_hit) begin
            case (i_cop_sel)
                PEC_SEL_CTRL0: rdata_next = 32'(c0_if.ctrl_q);
                PEC_SEL_CNT0:  rdata_next = c0_if.cnt_q;
                PEC_SEL_CTRL1: rdata_next = 32'(c1_if.ctrl_q);
                PEC_SEL_CNT1:  rdata_next = c1_if.cnt_q;
                default:       rdata_next = PEC_RDATA_RST;
            endcase
        end
    end

    // read data held until the next read
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_reg  <= PEC_RDATA_RST;
            rvalid_reg <= 1'b0;
        end else if (i_ce) begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign o_cop_rdata  = rdata_reg;
    assign o_cop_rvalid = rvalid_reg;

    // level from register bits only, so it falls when software rewrites the counter
    assign o_perf_overflow_irq_line =
        (c0_if.cnt_q[PEC_CNT_W-1] && c0_if.ctrl_q[PEC_IRQ_EN_BIT])
        || (c1_if.cnt_q[PEC_CNT_W-1] && c1_if.ctrl_q[PEC_IRQ_EN_BIT]);

    // the two counter slices
    pec_counter_slice u_slice0 (
        .i_core_clk             (i_core_clk),
        .i_rstn                 (i_rstn),
        .i_ce                   (i_ce),
        .i_ksu_mode             (i_ksu_mode),
        .i_exception_level_flag (i_exception_level_flag),
        .i_error_level_flag     (i_error_level_flag),
        .cnt_if                 (c0_if.slice)
    );

    pec_counter_slice u_slice1 (
        .i_core_clk             (i_core_clk),
        .i_rstn                 (i_rstn),
        .i_ce                   (i_ce),
        .i_ksu_mode             (i_ksu_mode),
        .i_exception_level_flag (i_exception_level_flag),
        .i_error_level_flag     (i_error_level_flag),
        .cnt_if                 (c1_if.slice)
    );

    // checks on counting, the overflow line and register reads and writes
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_st_issue;
        i_ce && i_st_first_issue && ev0 == PEC_EV_STORE;
    endsequence

    sequence s_c0_store_counting;
        i_ce && !c0_if.wr_cnt && !c0_if.wr_ctrl && c0_if.count_ok && ev0 == PEC_EV_STORE
        && !i_c0_evt_hi[6];
    endsequence

    sequence s_cst_grad;
        i_ce && i_store_conditional_grad && ev1 == PEC_EV_CST;
    endsequence

    sequence s_c1_cst_counting;
        i_ce && !c1_if.wr_cnt && !c1_if.wr_ctrl && c1_if.count_ok && ev1 == PEC_EV_CST;
    endsequence

    a_cycle_count: assert property (
        i_ce && ev0 == PEC_EV_CYCLES && c0_if.count_ok && !c0_if.wr_cnt
        |=> c0_if.cnt_q == $past(c0_if.cnt_q) + 32'h0000_0001
    ) else $error("counter 0 did not add one per cycle");

    a_wrap_continue: assert property (
        i_ce && ev1 == PEC_EV_CYCLES && c1_if.count_ok && !c1_if.wr_cnt
        && c1_if.cnt_q == 32'hFFFF_FFFF
        |=> c1_if.cnt_q == 32'h0000_0000
    ) else $error("counter 1 did not wrap to zero");

    a_irq_raise: assert property (
        $rose(c0_if.cnt_q[PEC_CNT_W-1]) && c0_if.ctrl_q[PEC_IRQ_EN_BIT]
        |-> o_perf_overflow_irq_line
    ) else $error("overflow did not raise the interrupt line");

    a_irq_gate: assert property (
        !c0_if.ctrl_q[PEC_IRQ_EN_BIT] && !c1_if.ctrl_q[PEC_IRQ_EN_BIT] |-> !o_perf_overflow_irq_line
    ) else $error("interrupt line high with both enables clear");

    a_halt_count: assert property (
        i_ce && i_error_level_flag && !c0_if.wr_cnt && !c1_if.wr_cnt
        |=> $stable(c0_if.cnt_q) && $stable(c1_if.cnt_q)
    ) else $error("counter moved while error level set");

    a_reserved_zero: assert property (
        i_ce && rd_hit && (i_cop_sel == PEC_SEL_CTRL0 || i_cop_sel == PEC_SEL_CTRL1)
        |=> o_cop_rvalid && o_cop_rdata[31:PEC_CTRL_W] == 23'h000000
    ) else $error("reserved control bits read nonzero");

    a_store_delay: assert property (
        s_st_issue ##1 s_c0_store_counting |=> c0_if.cnt_q == $past(c0_if.cnt_q) + 32'h0000_0001
    ) else $error("store issue not counted one cycle later");

    a_cst_grad_delay: assert property (
        s_cst_grad ##1 s_c1_cst_counting |=> c1_if.cnt_q == $past(c1_if.cnt_q) + 32'h0000_0001
    ) else $error("store-conditional graduation not counted one cycle later");

    a_grad_sum: assert property (
        (i_ce && ev1 == PEC_EV_INSTR)
        ##1 (i_ce && ev1 == PEC_EV_INSTR && c1_if.count_ok && !c1_if.wr_cnt && !c1_if.wr_ctrl)
        |=> c1_if.cnt_q == $past(c1_if.cnt_q) + 32'($past(i_grad_cnt, 2))
    ) else $error("graduation count not added on the following cycle");

    a_write_load: assert property (
        i_ce && wr_hit && i_cop_sel == PEC_SEL_CNT1 |=> c1_if.cnt_q == $past(i_cop_wdata)
    ) else $error("counter 1 write did not load the data");

    a_ce_freeze: assert property (
        !i_ce
        |=> $stable(c0_if.cnt_q) && $stable(c1_if.cnt_q) && $stable(c1_if.ctrl_q)
    ) else $error("state moved with enable low");

    a_fail_count: assert property (
        i_ce && ev0 == PEC_EV_FIVE && c0_if.count_ok && !c0_if.wr_cnt
        |=> c0_if.cnt_q == $past(c0_if.cnt_q) + 32'($past(i_store_conditional_fail))
    ) else $error("failed store-conditional not counted");

    a_read_count0: assert property (
        i_ce && rd_hit && i_cop_sel == PEC_SEL_CNT0
        |=> o_cop_rvalid && o_cop_rdata == $past(c0_if.cnt_q)
    ) else $error("counter 0 read wrong");

    a_load_issue: assert property (
        i_ce && ev0 == PEC_EV_LOAD && c0_if.count_ok && !c0_if.wr_cnt
        |=> c0_if.cnt_q == $past(c0_if.cnt_q) + 32'($past(i_ld_class_issue))
    ) else $error("load issue not counted");

endmodule : pec_perf_counters

// ---- tb/pec_perf_counters_tb.sv ----
// pec_perf_counters_tb: register and counting checks for the event counter block.
// assumes: block alone, reached through its coprocessor move ports, clock enable high except in the final enable-low check.
`timescale 1ns/100ps
module pec_perf_counters_tb;
    import pec_pkg::*;

    // stimulus and observed signals, named as the ports
    logic        i_core_clk                      = 1'b0;
    logic        i_rstn                          = 1'b0;
    logic        i_ce                            = 1'b1;
    logic        i_move_to_sys_coproc            = 1'b0;
    logic        i_move_from_sys_coproc          = 1'b0;
    logic [4:0]  i_cop_reg                       = PEC_COP_REG;
    logic [1:0]  i_cop_sel                       = 2'h0;
    logic [31:0] i_cop_wdata                     = 32'h0;
    logic [1:0]  i_ksu_mode                      = PEC_KSU_KERNEL;
    logic        i_exception_level_flag          = 1'b0;
    logic        i_error_level_flag              = 1'b1;
    logic [1:0]  i_int_done_cnt                  = 2'h0;
    logic [1:0]  i_fp_done_cnt                   = 2'h0;
    logic        i_ls_first_issue                = 1'b0;
    logic        i_ld_class_issue                = 1'b0;
    logic        i_st_first_issue                = 1'b0;
    logic        i_store_conditional_first_issue = 1'b0;
    logic        i_store_conditional_fail        = 1'b0;
    logic [15:6] i_c0_evt_hi                     = 10'h0;
    logic [3:0]  i_grad_cnt                      = 4'h0;
    logic [2:0]  i_ld_class_grad_cnt             = 3'h0;
    logic        i_st_grad                       = 1'b0;
    logic        i_store_conditional_grad        = 1'b0;
    logic [2:0]  i_fp_grad_cnt                   = 3'h0;
    logic [15:6] i_c1_evt_hi                     = 10'h0;
    logic [31:0] o_cop_rdata;
    logic        o_cop_rvalid;
    logic        o_perf_overflow_irq_line;
    int          fails      = 0;
    int          num_checks = 0;
    logic [31:0] rd;
    logic        seen;

    // mode table: enables, privilege, exception flag, count over three cycles
    logic [3:0]  md_t  [8] = '{4'h2, 4'h8, 4'h8, 4'h4, 4'h4, 4'h1, 4'h2, 4'hE};
    logic [1:0]  ksu_t [8] = '{2'h0, 2'h0, 2'h2, 2'h1, 2'h2, 2'h0, 2'h0, 2'h2};
    logic        xlv_t [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [31:0] mexp  [8] = '{32'h3, 32'h0, 32'h3, 32'h3, 32'h0, 32'h3, 32'h0, 32'h0};

    pec_perf_counters DUT (
        .i_core_clk, .i_rstn, .i_ce, .i_move_to_sys_coproc, .i_move_from_sys_coproc,
        .i_cop_reg, .i_cop_sel, .i_cop_wdata, .o_cop_rdata, .o_cop_rvalid, .i_ksu_mode,
        .i_exception_level_flag, .i_error_level_flag, .i_int_done_cnt, .i_fp_done_cnt,
        .i_ls_first_issue, .i_ld_class_issue, .i_st_first_issue,
        .i_store_conditional_first_issue, .i_store_conditional_fail, .i_c0_evt_hi,
        .i_grad_cnt, .i_ld_class_grad_cnt, .i_st_grad, .i_store_conditional_grad,
        .i_fp_grad_cnt, .i_c1_evt_hi, .o_perf_overflow_irq_line
    );

    // 40 MHz core clock
    always #12.5 i_core_clk = ~i_core_clk;

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask : chk_bit

    // one write move, held for exactly the edge that takes it
    task automatic cop_write(input logic [1:0] sel, input logic [31:0] data,
                             input logic [4:0] reg_n = PEC_COP_REG);
        @(posedge i_core_clk);
        i_move_to_sys_coproc <= 1'b1;
        i_cop_sel            <= sel;
        i_cop_wdata          <= data;
        i_cop_reg            <= reg_n;
        @(posedge i_core_clk);
        i_move_to_sys_coproc <= 1'b0;
    endtask : cop_write

    // one read move; waits a bounded time for the registered answer
    task automatic cop_read(input logic [1:0] sel, output logic [31:0] data,
                            output logic vld, input logic [4:0] reg_n = PEC_COP_REG);
        int i;
        vld = 1'b0;
        @(posedge i_core_clk);
        i_move_from_sys_coproc <= 1'b1;
        i_cop_sel              <= sel;
        i_cop_reg              <= reg_n;
        @(posedge i_core_clk);
        i_move_from_sys_coproc <= 1'b0;
        for (i = 0; i < 4 && !vld; i++) begin
            #1;
            if (o_cop_rvalid === 1'b1) begin
                vld = 1'b1;
            end else begin
                @(posedge i_core_clk);
            end
        end
        data = o_cop_rdata;
        if (!vld && reg_n == PEC_COP_REG) begin
            fails++;
            $display("unexpected at %0t: read answer never came", $time);
            final_report();
        end
    endtask : cop_read

    // lift the error level flag for exactly n sampling edges
    task automatic window(input int n);
        @(posedge i_core_clk);
        i_error_level_flag <= 1'b0;
        repeat (n) @(posedge i_core_clk);
        i_error_level_flag <= 1'b1;
    endtask : window

    // drive only the sources of code e, so a wrong selection reads zero
    task automatic set_src(input int e);
        @(posedge i_core_clk);
        i_int_done_cnt                  <= (e == 1) ? 2'h2 : 2'h0;
        i_fp_done_cnt                   <= (e == 1) ? 2'h2 : 2'h0;
        i_ls_first_issue                <= (e == 1);
        i_ld_class_issue                <= (e == 2);
        i_st_first_issue                <= (e == 3);
        i_store_conditional_first_issue <= (e == 4);
        i_store_conditional_fail        <= (e == 5);
        i_c0_evt_hi                     <= (e >= 6) ? (10'h001 << (e - 6)) : 10'h000;
        i_grad_cnt                      <= (e == 1) ? 4'h7 : 4'h0;
        i_ld_class_grad_cnt             <= (e == 2) ? 3'h4 : 3'h0;
        i_st_grad                       <= (e == 3);
        i_store_conditional_grad        <= (e == 4);
        i_fp_grad_cnt                   <= (e == 5) ? 3'h3 : 3'h0;
        i_c1_evt_hi                     <= (e >= 6) ? (10'h001 << (e - 6)) : 10'h000;
    endtask : set_src

    // counter 1 per-cycle increments implied by the sources above
    function automatic logic [31:0] inc1(input int e);
        case (e)
            1: return 32'h7;
            2: return 32'h4;
            5: return 32'h3;
            default: return 32'h1;
        endcase
    endfunction : inc1

    // main sequence
    initial begin
        int e;
        repeat (6) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        for (e = 0; e < 4; e++) begin
            cop_read(e[1:0], rd, seen);
            chk_word(rd, 32'h0);
        end
        cop_write(PEC_SEL_CTRL0, 32'h0000_01FF);
        cop_read(PEC_SEL_CTRL0, rd, seen);
        chk_word(rd, 32'h0000_01FF);
        cop_write(PEC_SEL_CNT0, 32'h1234_5678);
        cop_write(PEC_SEL_CNT1, 32'h9ABC_DEF0);
        cop_write(PEC_SEL_CNT0, 32'h0BAD_0BAD, 5'h18);
        cop_read(PEC_SEL_CNT0, rd, seen);
        chk_word(rd, 32'h1234_5678);
        cop_read(PEC_SEL_CNT1, rd, seen);
        chk_word(rd, 32'h9ABC_DEF0);
        chk_bit(o_perf_overflow_irq_line, 1'b0);
        cop_read(PEC_SEL_CNT0, rd, seen, 5'h18);
        chk_bit(seen, 1'b0);
        // every event code on both counters at once, kernel mode
        for (e = 0; e < 16; e++) begin
            set_src(e);
            cop_write(PEC_SEL_CTRL0, {23'h0, e[3:0], 5'h02});
            cop_write(PEC_SEL_CTRL1, {23'h0, e[3:0], 5'h02});
            cop_write(PEC_SEL_CNT0, 32'h0);
            cop_write(PEC_SEL_CNT1, 32'h0);
            window(5);
            cop_read(PEC_SEL_CNT0, rd, seen);
            chk_word(rd, (e == 1) ? 32'h19 : 32'h5);
            cop_read(PEC_SEL_CNT1, rd, seen);
            chk_word(rd, 32'h5 * inc1(e));
        end
        // mode qualifiers on the cycle event
        set_src(0);
        for (e = 0; e < 8; e++) begin
            @(posedge i_core_clk);
            i_ksu_mode             <= ksu_t[e];
            i_exception_level_flag <= xlv_t[e];
            cop_write(PEC_SEL_CTRL0, {27'h0, 1'b0, md_t[e]});
            cop_write(PEC_SEL_CNT0, 32'h0);
            window(3);
            cop_read(PEC_SEL_CNT0, rd, seen);
            chk_word(rd, mexp[e]);
        end
        // overflow line, counting past bit 31 and wrap
        @(posedge i_core_clk);
        i_ksu_mode             <= PEC_KSU_KERNEL;
        i_exception_level_flag <= 1'b0;
        cop_write(PEC_SEL_CTRL1, 32'h0000_0002);
        cop_write(PEC_SEL_CNT0, 32'h7FFF_FFFE);
        cop_write(PEC_SEL_CTRL0, 32'h0000_0012);
        #1;
        chk_bit(o_perf_overflow_irq_line, 1'b0);
        window(3);
        cop_read(PEC_SEL_CNT0, rd, seen);
        chk_word(rd, 32'h8000_0001);
        chk_bit(o_perf_overflow_irq_line, 1'b1);
        cop_write(PEC_SEL_CTRL0, 32'h0000_0002);
        #1;
        chk_bit(o_perf_overflow_irq_line, 1'b0);
        cop_write(PEC_SEL_CNT1, 32'hFFFF_FFFF);
        cop_write(PEC_SEL_CTRL1, 32'h0000_0012);
        #1;
        chk_bit(o_perf_overflow_irq_line, 1'b1);
        window(2);
        cop_read(PEC_SEL_CNT1, rd, seen);
        chk_word(rd, 32'h0000_0001);
        chk_bit(o_perf_overflow_irq_line, 1'b0);
        // enable low: no count, no move
        @(posedge i_core_clk);
        i_ce <= 1'b0;
        cop_write(PEC_SEL_CNT1, 32'h0000_0055);
        window(3);
        @(posedge i_core_clk);
        i_ce <= 1'b1;
        cop_read(PEC_SEL_CNT1, rd, seen);
        chk_word(rd, 32'h0000_0001);
        final_report();
    end

endmodule : pec_perf_counters_tb
